// >>> src/pin_ctrl_pkg.sv
/*
 Constants for the transceiver pin control decode block: APB offsets,
 field positions, reset values, pattern and rate encodings.
 Assumes a 32-bit APB bus with word-aligned registers.
*/
package pin_ctrl_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RATE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_ERR0 = 8'h10;
    localparam logic [7:0] OFS_ERR3 = 8'h1C;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_LANE_BIT = 0;
    localparam int CTRL_PCS_BIT = 1;
    localparam int CTRL_CLR_BIT = 2;
    localparam int STAT_C22 = 0;
    localparam int STAT_LANE = 1;
    localparam int STAT_PCS = 2;
    localparam int STAT_PAT = 3;
    localparam int STAT_LOWPWR = 4;
    localparam int STAT_SOFT = 5;
    localparam int STAT_DTE = 6;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [7:0] RATE_RST = 8'h00;
    // ----------------------------------------
    // Encodings and sizes
    // ----------------------------------------
    localparam int NCH = 4;
    localparam int CNT_W = 16;
    localparam int PRBS_LEN_LONG = 23;
    localparam int PRBS_TAP_LONG = 18;
    localparam int PRBS_LEN_SHORT = 7;
    localparam int PRBS_TAP_SHORT = 6;
    localparam logic [1:0] RATE_SOFT = 2'h3;
    localparam logic [4:0] DEV_PHY = 5'h04;
    localparam logic [4:0] DEV_DTE = 5'h05;
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    localparam logic [22:0] PRBS_SEED = 23'h7FFFFF;
endpackage

// >>> src/transceiver_pin_control_decode.sv
/*
 Pin control decode for a four-channel serial transceiver: strap
 capture, management address decode, code-enable qualification,
 pattern generation and checking, loopbacks, rate select, low power.
 Assumes straps and pins are asynchronous to pclk; serial bits,
 parallel data and management requests come from pclk logic.
*/
// The register offsets and the APB interface to the registers were decided locally.
// Summary of operation
// - clause select 1 gives 22, 0 gives 45
// - Clause 45 lane order = pin OR bit
// - Clause 22 PCS enable = pin OR bit
// - Pattern pin enables generators and checkers
// - Per-channel error counters readable by software
// - General output n pulses on channel errors
// - Clause 45 uses length 2^23-1 pattern
// - Clause 22 uses length 2^7-1 pattern
// - Serial loop repeats serial in to out
// - Parallel loop joins parallel in to out
// - Rate pins: full, half, quarter, software
// - Software mode: per-channel rate from registers
// - Rate governs receive and transmit alike
// - Rate register ignored outside software mode
// - Enable pin low means low power
// - Clause 45 lowest address pin picks PHY/DTE
// - Clause 45 upper four pins form address
// - Clause 22 upper three pins pick block
// - Clause 22 channel n answers offset n
// - Clause 45 answers device address 4 or 5
// - Bad writes ignored, bad reads return zero
`timescale 1ns/10ps
module transceiver_pin_control_decode (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Strap and control pins
    input wire logic clause_select_pin,
    input wire logic code_enable_pin,
    input wire logic pattern_test_enable_pin,
    input wire logic serial_loop_pin,
    input wire logic parallel_loop_pin,
    input wire logic [1:0] rate_select_pins,
    input wire logic device_enable_pin,
    input wire logic [4:0] port_address_pins,
    // Management transaction decode
    input wire logic mgmt_req,
    input wire logic [4:0] mgmt_phy_addr,
    input wire logic [4:0] mgmt_dev_addr,
    output logic mgmt_hit,
    output logic [3:0] mgmt_chan_sel,
    output logic mgmt_space_dte,
    // Channel datapaths, one bit per channel
    input wire logic [3:0] serial_rx,
    output logic [3:0] serial_tx,
    input wire logic [3:0] par_tx,
    output logic [3:0] par_rx,
    // Decoded configuration
    output logic clause22_mode,
    output logic lane_order_en,
    output logic coding_sublayer_en,
    output logic [7:0] channel_rate,
    output logic low_power,
    output logic [4:0] general_outputs
);
    // ----------------------------------------
    // Pattern feedback
    // ----------------------------------------
    function automatic logic prbs_fb(input logic [22:0] s,
                                     input logic long_seq);
        if (long_seq) begin
            prbs_fb = s[pin_ctrl_pkg::PRBS_LEN_LONG-1]
                ^ s[pin_ctrl_pkg::PRBS_TAP_LONG-1];
        end else begin
            prbs_fb = s[pin_ctrl_pkg::PRBS_LEN_SHORT-1]
                ^ s[pin_ctrl_pkg::PRBS_TAP_SHORT-1];
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [14:0] pin_meta_ff;
    logic [14:0] pin_sync_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_ff <= 15'h0000;
            pin_sync_ff <= 15'h0000;
        end else begin
            pin_meta_ff <= {clause_select_pin, code_enable_pin,
                pattern_test_enable_pin, serial_loop_pin,
                parallel_loop_pin, rate_select_pins,
                device_enable_pin, port_address_pins, 2'h0};
            pin_sync_ff <= pin_meta_ff;
        end
    end
    logic s_pat, s_ser_loop, s_par_loop, s_en;
    assign s_pat = pin_sync_ff[12];
    assign s_ser_loop = pin_sync_ff[11];
    assign s_par_loop = pin_sync_ff[10];
    assign s_en = pin_sync_ff[7];

    // ----------------------------------------
    // Strap capture after reset release
    // ----------------------------------------
    // Capture waits for the sync pipe to fill, so reset values never leak
    logic [1:0] wait_ff;
    logic strap_done_ff;
    logic c22_ff, code_ff;
    logic [1:0] rate_pin_ff;
    logic [4:0] port_addr_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_ff <= 2'h0;
            strap_done_ff <= 1'b0;
            c22_ff <= 1'b0;
            code_ff <= 1'b0;
            rate_pin_ff <= 2'h0;
            port_addr_ff <= 5'h00;
        end else if (!strap_done_ff) begin
            wait_ff <= wait_ff + 2'h1;
            if (wait_ff == pin_ctrl_pkg::STRAP_WAIT) begin
                strap_done_ff <= 1'b1;
                c22_ff <= pin_sync_ff[14];
                code_ff <= pin_sync_ff[13];
                rate_pin_ff <= pin_sync_ff[9:8];
                port_addr_ff <= pin_sync_ff[6:2];
            end
        end
    end

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    logic lane_bit_ff, pcs_bit_ff, clr_ff;
    logic [7:0] rate_reg_ff;
    logic [pin_ctrl_pkg::CNT_W-1:0] err_cnt_ff [pin_ctrl_pkg::NCH];
    logic setup, wr_access;
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite && pready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_bit_ff <= pin_ctrl_pkg::CTRL_RST[0];
            pcs_bit_ff <= pin_ctrl_pkg::CTRL_RST[1];
            clr_ff <= 1'b0;
            rate_reg_ff <= pin_ctrl_pkg::RATE_RST;
        end else begin
            clr_ff <= 1'b0;
            // Status and counters are read-only; writes there drop
            if (wr_access && paddr == pin_ctrl_pkg::OFS_CTRL) begin
                lane_bit_ff <= pwdata[pin_ctrl_pkg::CTRL_LANE_BIT];
                pcs_bit_ff <= pwdata[pin_ctrl_pkg::CTRL_PCS_BIT];
                clr_ff <= pwdata[pin_ctrl_pkg::CTRL_CLR_BIT];
            end else if (wr_access && paddr == pin_ctrl_pkg::OFS_RATE) begin
                rate_reg_ff <= pwdata[7:0];
            end
        end
    end

    logic [31:0] status;
    assign status = {25'h0, port_addr_ff[0],
        rate_pin_ff == pin_ctrl_pkg::RATE_SOFT, low_power,
        s_pat, coding_sublayer_en, lane_order_en, c22_ff};
    // Read data is staged in the setup cycle; answer comes one cycle on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= 1'b0;
            if (setup && !pwrite) begin
                if (paddr == pin_ctrl_pkg::OFS_CTRL) begin
                    prdata <= {30'h0, pcs_bit_ff, lane_bit_ff};
                end else if (paddr == pin_ctrl_pkg::OFS_RATE) begin
                    prdata <= {24'h0, rate_reg_ff};
                end else if (paddr == pin_ctrl_pkg::OFS_STATUS) begin
                    prdata <= status;
                end else if (paddr >= pin_ctrl_pkg::OFS_ERR0 &&
                             paddr <= pin_ctrl_pkg::OFS_ERR3 &&
                             paddr[1:0] == 2'h0) begin
                    prdata <= {16'h0, err_cnt_ff[paddr[3:2]]};
                end else begin
                    prdata <= 32'h00000000;
                end
            end else if (setup) begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // Decoded configuration
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clause22_mode <= 1'b0;
            lane_order_en <= 1'b0;
            coding_sublayer_en <= 1'b0;
            low_power <= 1'b1;
        end else begin
            clause22_mode <= c22_ff;
            lane_order_en <= !c22_ff && (code_ff || lane_bit_ff);
            coding_sublayer_en <= c22_ff && (code_ff || pcs_bit_ff);
            // Enable level changes expect a reset to follow
            low_power <= !s_en;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_rate <= 8'h00;
        end else begin
            for (int n = 0; n < pin_ctrl_pkg::NCH; n++) begin
                // One setting drives both directions of each channel
                if (rate_pin_ff == pin_ctrl_pkg::RATE_SOFT) begin
                    channel_rate[2*n +: 2] <= rate_reg_ff[2*n +: 2];
                end else begin
                    channel_rate[2*n +: 2] <= rate_pin_ff;
                end
            end
        end
    end

    // ----------------------------------------
    // Management address decode
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mgmt_hit <= 1'b0;
            mgmt_chan_sel <= 4'h0;
            mgmt_space_dte <= 1'b0;
        end else begin
            mgmt_hit <= 1'b0;
            mgmt_chan_sel <= 4'h0;
            mgmt_space_dte <= port_addr_ff[0];
            if (mgmt_req && strap_done_ff && c22_ff) begin
                if (mgmt_phy_addr[4:2] == port_addr_ff[4:2]) begin
                    mgmt_hit <= 1'b1;
                    mgmt_chan_sel <= 4'h1 << mgmt_phy_addr[1:0];
                end
            end else if (mgmt_req && strap_done_ff) begin
                if (mgmt_phy_addr == {port_addr_ff[4:1], 1'b0} &&
                    mgmt_dev_addr == (port_addr_ff[0] ? pin_ctrl_pkg::DEV_DTE
                                      : pin_ctrl_pkg::DEV_PHY)) begin
                    mgmt_hit <= 1'b1;
                    mgmt_chan_sel <= 4'hF;
                end
            end
        end
    end

    // ----------------------------------------
    // Pattern generation and checking
    // ----------------------------------------
    // Receive path relies on the external serial loop during test
    logic [22:0] gen_ff [pin_ctrl_pkg::NCH];
    logic [22:0] chk_ff [pin_ctrl_pkg::NCH];
    logic [3:0] err_ff;
    logic pat_on;
    assign pat_on = s_pat && s_en;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int n = 0; n < pin_ctrl_pkg::NCH; n++) begin
                gen_ff[n] <= pin_ctrl_pkg::PRBS_SEED;
                chk_ff[n] <= 23'h000000;
            end
            err_ff <= 4'h0;
        end else begin
            for (int n = 0; n < pin_ctrl_pkg::NCH; n++) begin
                if (pat_on) begin
                    gen_ff[n] <= {gen_ff[n][21:0],
                                  prbs_fb(gen_ff[n], !c22_ff)};
                    chk_ff[n] <= {chk_ff[n][21:0], serial_rx[n]};
                    err_ff[n] <= serial_rx[n]
                        != prbs_fb(chk_ff[n], !c22_ff);
                end else begin
                    err_ff[n] <= 1'b0;
                end
            end
        end
    end

    // Counters saturate so a long soak never wraps to a false pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int n = 0; n < pin_ctrl_pkg::NCH; n++) begin
                err_cnt_ff[n] <= 16'h0000;
            end
        end else begin
            for (int n = 0; n < pin_ctrl_pkg::NCH; n++) begin
                if (err_ff[n] && err_cnt_ff[n] != 16'hFFFF) begin
                    err_cnt_ff[n] <= err_cnt_ff[n] + 16'h0001;
                end else if (clr_ff) begin
                    err_cnt_ff[n] <= 16'h0000;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_outputs <= 5'h00;
        end else begin
            general_outputs <= {1'b0, err_ff};
        end
    end

    // ----------------------------------------
    // Datapath and loopbacks
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_tx <= 4'h0;
            par_rx <= 4'h0;
        end else if (!s_en) begin
            serial_tx <= 4'h0;
            par_rx <= 4'h0;
        end else begin
            for (int n = 0; n < pin_ctrl_pkg::NCH; n++) begin
                if (s_ser_loop) begin
                    serial_tx[n] <= serial_rx[n];
                end else if (pat_on) begin
                    serial_tx[n] <= gen_ff[n][0];
                end else begin
                    serial_tx[n] <= par_tx[n];
                end
                par_rx[n] <= s_par_loop ? par_tx[n] : serial_rx[n];
            end
        end
    end
endmodule

// >>> tb/pin_ctrl_props.sv
/*
 Checker on the ports of the pin control decode block.
 Assumes strap pins only change while presetn is low.
*/
`timescale 1ns/10ps
module pin_ctrl_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pins
    input wire logic clause_select_pin,
    input wire logic pattern_test_enable_pin,
    input wire logic serial_loop_pin,
    input wire logic parallel_loop_pin,
    input wire logic [1:0] rate_select_pins,
    input wire logic device_enable_pin,
    // Management and lanes
    input wire logic [4:0] mgmt_phy_addr,
    input wire logic [4:0] mgmt_dev_addr,
    input wire logic mgmt_hit,
    input wire logic [3:0] mgmt_chan_sel,
    input wire logic mgmt_space_dte,
    input wire logic [3:0] serial_rx,
    input wire logic [3:0] serial_tx,
    input wire logic [3:0] par_tx,
    input wire logic [3:0] par_rx,
    // Decoded outputs
    input wire logic clause22_mode,
    input wire logic lane_order_en,
    input wire logic coding_sublayer_en,
    input wire logic [7:0] channel_rate,
    input wire logic low_power,
    input wire logic [4:0] general_outputs
);
    logic [2:0] rel_cnt_ff;
    logic [4:0] req_pa_ff;
    logic [4:0] req_da_ff;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Straps are only trusted once the capture has settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rel_cnt_ff <= 3'h0;
        else if (rel_cnt_ff != 3'h7) rel_cnt_ff <= rel_cnt_ff + 3'h1;
    end
    always_ff @(posedge pclk) begin
        req_pa_ff <= mgmt_phy_addr;
        req_da_ff <= mgmt_dev_addr;
    end
    property p_mode; rel_cnt_ff == 3'h7 |-> clause22_mode == clause_select_pin;
    endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
    property p_lane; clause22_mode |-> !lane_order_en; endproperty
    a_lane: assert property (p_lane) else $error("lane in c22");
    property p_pcs; !clause22_mode |-> !coding_sublayer_en; endproperty
    a_pcs: assert property (p_pcs) else $error("pcs in c45");
    property p_gen_out;
        !pattern_test_enable_pin [*6] |-> general_outputs == 5'h00;
    endproperty
    a_gen_out: assert property (p_gen_out) else $error("outputs high");
    property p_ser_loop; (serial_loop_pin && device_enable_pin) [*6]
        |-> serial_tx == $past(serial_rx); endproperty
    a_ser_loop: assert property (p_ser_loop) else $error("serial loop");
    property p_par_loop; (parallel_loop_pin && device_enable_pin) [*6]
        |-> par_rx == $past(par_tx); endproperty
    a_par_loop: assert property (p_par_loop) else $error("par loop");
    property p_rate; rel_cnt_ff == 3'h7 && rate_select_pins != 2'h3
        |-> channel_rate == {4{rate_select_pins}}; endproperty
    a_rate: assert property (p_rate) else $error("rate");
    property p_lp;
        $stable(device_enable_pin) [*6] |-> low_power == !device_enable_pin;
    endproperty
    a_lp: assert property (p_lp) else $error("low power");
    property p_c22; mgmt_hit && clause22_mode
        |-> mgmt_chan_sel == 4'h1 << req_pa_ff[1:0]; endproperty
    a_c22: assert property (p_c22) else $error("c22 chan");
    property p_c45; mgmt_hit && !clause22_mode |-> mgmt_chan_sel == 4'hF
        && req_da_ff == (mgmt_space_dte ? 5'h05 : 5'h04); endproperty
    a_c45: assert property (p_c45) else $error("c45 dev");
    c_hit: cover property (mgmt_hit && clause22_mode);
    c_err: cover property (general_outputs[2]);
    c_lp: cover property (low_power);
endmodule
bind transceiver_pin_control_decode pin_ctrl_props pin_ctrl_props_i (
    .pclk, .presetn, .clause_select_pin, .pattern_test_enable_pin,
    .serial_loop_pin, .parallel_loop_pin, .rate_select_pins,
    .device_enable_pin, .mgmt_phy_addr, .mgmt_dev_addr, .mgmt_hit,
    .mgmt_chan_sel, .mgmt_space_dte, .serial_rx, .serial_tx, .par_tx,
    .par_rx, .clause22_mode, .lane_order_en, .coding_sublayer_en,
    .channel_rate, .low_power, .general_outputs
);

// >>> tb/board_side_model.sv
/*
 Board side: loopback cabling of the serial lanes.
 Assumes one serial bit per lane per pclk cycle.
*/
`timescale 1ns/10ps
module board_side_model (
    // Clock
    input wire logic pclk,
    // Bench control
    input wire logic ext_loop,
    input wire logic [3:0] flip_mask,
    // Lanes
    input wire logic [3:0] serial_tx,
    output logic [3:0] serial_rx
);
    // Open lanes wander so a stale bit never passes for data
    always_ff @(posedge pclk) begin
        if (ext_loop) begin
            serial_rx <= serial_tx ^ flip_mask;
        end else begin
            serial_rx <= 4'($urandom);
        end
    end
endmodule

// >>> tb/transceiver_pin_control_decode_test.sv
/*
 Self-checking bench for the pin control decode block.
 Assumes the board side model loops the lanes on request.
*/
`timescale 1ns/10ps
module transceiver_pin_control_decode_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic clause_select_pin = 1'b0, code_enable_pin = 1'b0;
    logic pattern_test_enable_pin = 1'b0, device_enable_pin = 1'b1;
    logic serial_loop_pin = 1'b0, parallel_loop_pin = 1'b0;
    logic [1:0] rate_select_pins = 2'h0;
    logic [4:0] port_address_pins = 5'h00, mgmt_phy_addr = 5'h00;
    logic [4:0] mgmt_dev_addr = 5'h00, general_outputs;
    logic mgmt_req = 1'b0, mgmt_hit, mgmt_space_dte, ext_loop = 1'b0;
    logic [3:0] mgmt_chan_sel, serial_rx, serial_tx, par_rx;
    logic [3:0] par_tx = 4'h0, flip_mask = 4'h0;
    logic clause22_mode, lane_order_en, coding_sublayer_en, low_power;
    logic [7:0] channel_rate;
    int failures = 0, num_checks = 0;

    always #2 pclk = ~pclk;

    transceiver_pin_control_decode transceiver_pin_control_decode_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .clause_select_pin, .code_enable_pin,
        .pattern_test_enable_pin, .serial_loop_pin, .parallel_loop_pin,
        .rate_select_pins, .device_enable_pin, .port_address_pins,
        .mgmt_req, .mgmt_phy_addr, .mgmt_dev_addr, .mgmt_hit,
        .mgmt_chan_sel, .mgmt_space_dte, .serial_rx, .serial_tx, .par_tx,
        .par_rx, .clause22_mode, .lane_order_en, .coding_sublayer_en,
        .channel_rate, .low_power, .general_outputs
    );
    board_side_model board_side_model_i (
        .pclk, .ext_loop, .flip_mask, .serial_tx, .serial_rx
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        chk(32'({n < 16, pslverr}), 32'h2);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [3:0] exp_sel(input logic [4:0] pa, da);
        logic [4:0] dev;
        dev = port_address_pins[0] ? pin_ctrl_pkg::DEV_DTE
                                   : pin_ctrl_pkg::DEV_PHY;
        if (clause_select_pin)
            return pa[4:2] == port_address_pins[4:2] ? 4'h1 << pa[1:0] : 4'h0;
        return pa == {port_address_pins[4:1], 1'b0} && da == dev ? 4'hF : 4'h0;
    endfunction
    task automatic mreq(input logic [4:0] pa, input logic [4:0] da);
        logic [3:0] e;
        e = exp_sel(pa, da);
        mgmt_req <= 1'b1;
        mgmt_phy_addr <= pa;
        mgmt_dev_addr <= da;
        @(posedge pclk);
        mgmt_req <= 1'b0;
        @(posedge pclk);
        chk(32'({mgmt_space_dte, mgmt_hit, mgmt_chan_sel}),
            32'({port_address_pins[0], e != 4'h0, e}));
    endtask
    task automatic boot(input int k);
        presetn <= 1'b0;
        clause_select_pin <= k[0];
        code_enable_pin <= k[1];
        rate_select_pins <= 2'(k);
        port_address_pins <= 5'($urandom);
        device_enable_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask
    task automatic pattern;
        logic [22:0] hist;
        logic [31:0] r;
        int pulses;
        pulses = 0;
        hist = 23'h0;
        pattern_test_enable_pin <= 1'b1;
        ext_loop <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b1, pin_ctrl_pkg::OFS_CTRL, 32'h7, r);
        flip_mask <= 4'h4;
        @(posedge pclk);
        flip_mask <= 4'h0;
        for (int i = 0; i < 64; i++) begin
            @(posedge pclk);
            if (i >= 23) chk(32'(serial_tx[0]), 32'(clause_select_pin ?
                hist[6] ^ hist[5] : hist[22] ^ hist[17]));
            hist = {hist[21:0], serial_tx[0]};
            pulses += int'(general_outputs[2] === 1'b1);
            chk(32'(general_outputs & 5'h1B), 32'h0);
        end
        chk(pulses, 3);
        for (int n = 0; n < 4; n++) begin
            apb(1'b0, pin_ctrl_pkg::OFS_ERR0 + 8'(4 * n), 32'h0, r);
            chk(r, n == 2 ? 32'h3 : 32'h0);
        end
        pattern_test_enable_pin <= 1'b0;
        ext_loop <= 1'b0;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r, v;
        logic [4:0] pa;
        void'($urandom(89915));
        for (int k = 0; k < 4; k++) begin
            boot(k);
            chk(32'({clause22_mode, lane_order_en, coding_sublayer_en}),
                32'({k[0], ~k[0] & k[1], k[0] & k[1]}));
            apb(1'b1, pin_ctrl_pkg::OFS_CTRL, 32'h3, r);
            // Decoded outputs follow the register one edge later
            @(posedge pclk);
            chk(32'({lane_order_en, coding_sublayer_en}),
                32'({~k[0], k[0]}));
            v = $urandom;
            apb(1'b1, pin_ctrl_pkg::OFS_RATE, v, r);
            @(posedge pclk);
            chk(32'(channel_rate), k == 3 ? 32'(v[7:0])
                : 32'({4{2'(k)}}));
            apb(1'b1, pin_ctrl_pkg::OFS_STATUS, v, r);
            apb(1'b0, pin_ctrl_pkg::OFS_STATUS, 32'h0, r);
            chk(r, 32'({port_address_pins[0], k == 3, 2'h0, k[0], ~k[0],
                k[0]}));
            apb(1'b0, 8'h40, 32'h0, r);
            chk(r, 32'h0);
            for (int i = 0; i < 16; i++) begin
                pa = clause_select_pin ? {port_address_pins[4:2], i[2:1]}
                                       : {port_address_pins[4:1], i[1]};
                if (i[0]) pa = 5'($urandom);
                mreq(pa, i[3] ? 5'h05 : 5'h04);
            end
            pattern;
            serial_loop_pin <= 1'b1;
            parallel_loop_pin <= 1'b1;
            for (int i = 0; i < 20; i++) begin
                par_tx <= 4'($urandom);
                @(posedge pclk);
            end
            @(posedge pclk);
            chk(32'(par_rx), 32'(par_tx));
            serial_loop_pin <= 1'b0;
            parallel_loop_pin <= 1'b0;
            device_enable_pin <= 1'b0;
            repeat (5) @(posedge pclk);
            chk(32'({low_power, serial_tx, par_rx}), 32'h100);
            $display("run %0d done", k);
        end
        stop_test;
    end
    // About twelve times the expected run length
    initial begin
        #40000;
        failures++;
        stop_test;
    end
endmodule
